// ---- inc/bpt_pkg.sv ----
/*
 * Shared constants for the batch preset totalizer: register map, control
 * field positions, reset values, timing figures and the batch state type.
 * Assumes a 40 MHz register clock; every cycle count derives from CLK_HZ.
 */
`default_nettype none
package bpt_pkg;
    // Clock rate of pclk.
    localparam longint unsigned CLK_HZ = 64'd40_000_000;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_FACTOR = 8'h04;
    localparam logic [7:0] A_PRESET = 8'h08;
    localparam logic [7:0] A_TARGET = 8'h0C;
    localparam logic [7:0] A_BATCH = 8'h10;
    localparam logic [7:0] A_GRAND = 8'h14;
    localparam logic [7:0] A_STATUS = 8'h18;
    localparam logic [7:0] A_INT_STAT = 8'h1C;
    localparam logic [7:0] A_INT_MASK = 8'h20;
    localparam logic [7:0] A_DAMP = 8'h24;

    // Control register field positions.
    localparam int CB_PROT_OFF = 0;
    localparam int CB_MODE_PRESET = 1;
    localparam int CB_IN_FUNC = 2;
    localparam int CB_OUT_FUNC = 4;
    localparam int CB_FILTER_EN = 5;
    localparam int CB_SLOW_EXC = 6;
    localparam int CB_KEY_START = 7;

    // Contact input function codes.
    localparam logic [1:0] IN_NONE = 2'h0;
    localparam logic [1:0] IN_START = 2'h1;
    localparam logic [1:0] IN_ZERO_RET = 2'h2;

    // Interrupt status bit positions.
    localparam int IB_START = 0;
    localparam int IB_DONE = 1;
    localparam int IB_ZERO_RET = 2;
    localparam int IB_REFUSED = 3;

    // Values after reset, and the error code shown during zero return.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] FACTOR_RST = 16'h000A;
    localparam logic [15:0] PRESET_RST = 16'h012C;
    localparam logic [3:0] DAMP_RST = 4'h4;
    localparam logic [3:0] ERR_CODE_ZR = 4'h4;

    // Least hold time of the start contact, and the longest it may be held.
    localparam longint unsigned START_MIN_MS = 64'd350;
    localparam longint unsigned START_MAX_MS = 64'd1500;
    localparam longint unsigned START_MIN_CYC =
        (START_MIN_MS * CLK_HZ + 64'd999) / 64'd1000;
    // Least batch length under slow excitation.
    localparam longint unsigned MIN_BATCH_S = 64'd180;
    localparam longint unsigned MIN_BATCH_CYC = MIN_BATCH_S * CLK_HZ;
    // Period of each half of the zero-return message alternation.
    localparam longint unsigned ALT_MS = 64'd1000;
    localparam longint unsigned ALT_CYC = ALT_MS * CLK_HZ / 64'd1000;

    // Batch sequencer states.
    typedef enum logic [0:0] {ST_IDLE, ST_RUN} bpt_state_e;
endpackage
`default_nettype wire

// ---- hw/bpt_contact_qual.sv ----
/*
 * Start contact qualifier: emits one pulse when the contact has been held
 * closed for the least hold time, once per closure.
 * Assumes the contact level is already synchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module bpt_contact_qual #(
    parameter int unsigned HOLD_CYC = 14_000_000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic contact,
    output logic start_pulse
);
    logic [31:0] hold_cnt;

    ////////////////////////////////////////////////////////////////////////
    // hold time qualification
    // Short bounces never reach the count, and a long hold fires only once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt <= 32'h0;
            start_pulse <= 1'b0;
        end else if (!contact) begin
            hold_cnt <= 32'h0;
            start_pulse <= 1'b0;
        end else begin
            if (hold_cnt < HOLD_CYC) begin
                hold_cnt <= hold_cnt + 32'h1;
            end
            start_pulse <= (hold_cnt == HOLD_CYC - 1);
        end
    end
endmodule
`default_nettype wire

// ---- hw/bpt_flow_filter.sv ----
/*
 * First-order smoothing filter for the displayed flowrate and the current
 * output value. Assumes an unsigned 16-bit rate sample each cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module bpt_flow_filter #(
    parameter int W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic [3:0] damp_shift,
    input wire logic [W-1:0] rate_in,
    output logic [W-1:0] rate_out
);
    logic [2*W-1:0] acc;
    logic signed [2*W:0] diff;

    // Difference between the new sample and the smoothed value.
    assign diff = $signed({1'b0, rate_in, {W{1'b0}}}) - $signed({1'b0, acc});

    ////////////////////////////////////////////////////////////////////////
    // smoothing with lag
    // The smoothing scales each step down by 2 to the power damp_shift, so the smoothed value
    // trails the input and the response time grows with the damping.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= '0;
        end else if (!enable) begin
            acc <= {rate_in, {W{1'b0}}};
        end else begin
            acc <= acc + (2*W)'(diff >>> damp_shift);
        end
    end

    // The upper half of the accumulator is the smoothed rate.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_out <= '0;
        end else begin
            rate_out <= acc[2*W-1:W];
        end
    end
endmodule
`default_nettype wire

// ---- hw/bpt_top.sv ----
/*
 * Batch preset totalizer with external zero return, as an APB slave.
 * Assumes flow pulses and the contact level are synchronous to pclk, and
 * that software configures the block before starting batches.
 */
`timescale 1ns/1ps
`default_nettype none
module bpt_top #(
    parameter int unsigned START_MIN_CYC = int'(bpt_pkg::START_MIN_CYC),
    parameter logic [32:0] MIN_BATCH_CYC = 33'(bpt_pkg::MIN_BATCH_CYC),
    parameter int unsigned ALT_CYC = int'(bpt_pkg::ALT_CYC)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic start_contact_input,
    input wire logic flow_pulse,
    input wire logic [15:0] flow_rate,
    output logic end_contact_output,
    output logic batch_active,
    output logic outputs_on,
    output logic [15:0] disp_rate,
    output logic [15:0] current_value,
    output logic disp_zr_msg,
    output logic [3:0] disp_err_code,
    output logic irq
);
    bpt_pkg::bpt_state_e state;
    logic [7:0] ctrl;
    logic [15:0] factor;
    logic [15:0] preset;
    logic [3:0] damp;
    logic [31:0] target;
    logic [31:0] batch_cnt;
    logic [31:0] grand_total;
    logic [32:0] run_time;
    logic [3:0] int_stat;
    logic [3:0] int_mask;
    logic [31:0] alt_cnt;
    logic zero_ret;
    logic zero_ret_d;
    logic contact_start;
    logic key_start;
    logic start_req;
    logic cfg_ok;
    logic start_ok;
    logic min_ok;
    logic done;
    logic wr;
    logic [15:0] filt_rate;
    logic [3:0] next_int_stat;

    ////////////////////////////////////////////////////////////////////////
    // APB handshake: zero wait states, read data is captured in setup.
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;

    // Read mux and unmapped-address error, latched in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= 1'b0;
            if (paddr == bpt_pkg::A_CTRL) begin
                prdata <= {24'h0, 1'b0, ctrl[6:0]};
            end else if (paddr == bpt_pkg::A_FACTOR) begin
                prdata <= {16'h0, factor};
            end else if (paddr == bpt_pkg::A_PRESET) begin
                prdata <= {16'h0, preset};
            end else if (paddr == bpt_pkg::A_TARGET) begin
                prdata <= target;
            end else if (paddr == bpt_pkg::A_BATCH) begin
                prdata <= batch_cnt;
            end else if (paddr == bpt_pkg::A_GRAND) begin
                prdata <= grand_total;
            end else if (paddr == bpt_pkg::A_STATUS) begin
                prdata <= {24'h0, disp_err_code, disp_zr_msg, zero_ret,
                           end_contact_output, batch_active};
            end else if (paddr == bpt_pkg::A_INT_STAT) begin
                prdata <= {28'h0, int_stat};
            end else if (paddr == bpt_pkg::A_INT_MASK) begin
                prdata <= {28'h0, int_mask};
            end else if (paddr == bpt_pkg::A_DAMP) begin
                prdata <= {28'h0, damp};
            end else begin
                prdata <= 32'h0;
                pslverr <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register. The mode bit is locked while protection is on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= bpt_pkg::CTRL_RST;
        end else if (wr && paddr == bpt_pkg::A_CTRL) begin
            ctrl[6:2] <= pwdata[6:2];
            ctrl[bpt_pkg::CB_PROT_OFF] <= pwdata[bpt_pkg::CB_PROT_OFF];
            if (ctrl[bpt_pkg::CB_PROT_OFF]) begin
                ctrl[bpt_pkg::CB_MODE_PRESET] <=
                    pwdata[bpt_pkg::CB_MODE_PRESET];
            end
        end
    end

    // Keypad start is a write-one command bit that reads as zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_start <= 1'b0;
        end else begin
            key_start <= wr && paddr == bpt_pkg::A_CTRL &&
                         pwdata[bpt_pkg::CB_KEY_START];
        end
    end

    // Batch settings and filter damping.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            factor <= bpt_pkg::FACTOR_RST;
            preset <= bpt_pkg::PRESET_RST;
            damp <= bpt_pkg::DAMP_RST;
            int_mask <= 4'h0;
        end else if (wr) begin
            if (paddr == bpt_pkg::A_FACTOR) begin
                factor <= pwdata[15:0];
            end else if (paddr == bpt_pkg::A_PRESET) begin
                preset <= pwdata[15:0];
            end else if (paddr == bpt_pkg::A_DAMP) begin
                damp <= pwdata[3:0];
            end else if (paddr == bpt_pkg::A_INT_MASK) begin
                int_mask <= pwdata[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Contact input: the shared terminals serve either start or zero return.
    bpt_contact_qual #(
        .HOLD_CYC(START_MIN_CYC)
    ) u_qual (
        .pclk(pclk),
        .presetn(presetn),
        .contact(start_contact_input &&
                 ctrl[3:2] == bpt_pkg::IN_START),
        .start_pulse(contact_start)
    );

    assign zero_ret = start_contact_input &&
                      ctrl[3:2] == bpt_pkg::IN_ZERO_RET;

    assign start_req = key_start || contact_start;
    assign cfg_ok = ctrl[bpt_pkg::CB_MODE_PRESET] &&
                    ctrl[3:2] == bpt_pkg::IN_START &&
                    ctrl[bpt_pkg::CB_OUT_FUNC];
    assign start_ok = start_req && cfg_ok && state == bpt_pkg::ST_IDLE;

    assign min_ok = !ctrl[bpt_pkg::CB_SLOW_EXC] || run_time >= MIN_BATCH_CYC;
    assign done = state == bpt_pkg::ST_RUN && !zero_ret &&
                  batch_cnt >= target && min_ok;

    ////////////////////////////////////////////////////////////////////////
    // batch sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= bpt_pkg::ST_IDLE;
        end else begin
            case (state)
                bpt_pkg::ST_IDLE: begin
                    if (start_ok) begin
                        state <= bpt_pkg::ST_RUN;
                    end
                end
                bpt_pkg::ST_RUN: begin
                    if (done) begin
                        state <= bpt_pkg::ST_IDLE;
                    end
                end
                default: state <= bpt_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target <= 32'h0;
        end else if (start_ok) begin
            target <= 32'(factor) * 32'(preset);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            batch_cnt <= 32'h0;
        end else if (start_ok) begin
            batch_cnt <= 32'h0;
        end else if (state == bpt_pkg::ST_RUN && flow_pulse && !zero_ret) begin
            batch_cnt <= batch_cnt + 32'h1;
        end
    end

    // Run timer saturates so that a long batch never wraps it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_time <= 33'h0;
        end else if (start_ok) begin
            run_time <= 33'h0;
        end else if (state == bpt_pkg::ST_RUN && run_time < MIN_BATCH_CYC) begin
            run_time <= run_time + 33'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grand_total <= 32'h0;
        end else if (done) begin
            grand_total <= grand_total + batch_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // end contact control
    // Outputs go dead in zero return, so the contact opens meanwhile.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            end_contact_output <= 1'b0;
            batch_active <= 1'b0;
            outputs_on <= 1'b0;
        end else begin
            batch_active <= (state == bpt_pkg::ST_RUN && !done) || start_ok;
            end_contact_output <= ((state == bpt_pkg::ST_RUN && !done) ||
                                   start_ok) && !zero_ret;
            outputs_on <= !zero_ret;
        end
    end

    bpt_flow_filter #(
        .W(16)
    ) u_filt (
        .pclk(pclk),
        .presetn(presetn),
        .enable(ctrl[bpt_pkg::CB_FILTER_EN]),
        .damp_shift(damp),
        .rate_in(flow_rate),
        .rate_out(filt_rate)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_rate <= 16'h0;
            current_value <= 16'h0;
        end else begin
            disp_rate <= zero_ret ? 16'h0 : filt_rate;
            current_value <= zero_ret ? 16'h0 : filt_rate;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alternating zero-return display
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_cnt <= 32'h0;
            disp_zr_msg <= 1'b0;
            disp_err_code <= 4'h0;
        end else if (!zero_ret) begin
            alt_cnt <= 32'h0;
            disp_zr_msg <= 1'b0;
            disp_err_code <= 4'h0;
        end else if (alt_cnt == ALT_CYC - 1) begin
            alt_cnt <= 32'h0;
            disp_zr_msg <= !disp_zr_msg;
            disp_err_code <= disp_zr_msg ? bpt_pkg::ERR_CODE_ZR : 4'h0;
        end else begin
            alt_cnt <= alt_cnt + 32'h1;
            if (!disp_zr_msg) begin
                disp_err_code <= bpt_pkg::ERR_CODE_ZR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky interrupt status; a new event wins over a same-cycle clear.
    always_comb begin
        next_int_stat = int_stat;
        if (wr && paddr == bpt_pkg::A_INT_STAT) begin
            next_int_stat = int_stat & ~pwdata[3:0];
        end
        next_int_stat[bpt_pkg::IB_START] = next_int_stat[bpt_pkg::IB_START] |
                                           start_ok;
        next_int_stat[bpt_pkg::IB_DONE] = next_int_stat[bpt_pkg::IB_DONE] |
                                          done;
        next_int_stat[bpt_pkg::IB_ZERO_RET] =
            next_int_stat[bpt_pkg::IB_ZERO_RET] | (zero_ret && !zero_ret_d);
        next_int_stat[bpt_pkg::IB_REFUSED] =
            next_int_stat[bpt_pkg::IB_REFUSED] | (start_req && !start_ok);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat <= 4'h0;
            zero_ret_d <= 1'b0;
            irq <= 1'b0;
        end else begin
            int_stat <= next_int_stat;
            zero_ret_d <= zero_ret;
            irq <= |(next_int_stat & int_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the batch sequence.
    sequence start_seq;
        start_req && cfg_ok && !batch_active && state == bpt_pkg::ST_IDLE;
    endsequence

    sequence zr_seq;
        zero_ret ##1 zero_ret;
    endsequence

    batch_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_seq |=> batch_active && batch_cnt == 32'h0)
        else $error("accepted start did not begin a batch");

    end_close_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_seq ##0 !zero_ret |=> end_contact_output)
        else $error("end contact not closed at batch start");

    end_open_a: assert property (@(posedge pclk) disable iff (!presetn)
        done |=> !batch_active && !end_contact_output)
        else $error("batch indicator still set after completion");

    target_calc_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_seq |=> target == $past(factor) * $past(preset))
        else $error("target is not factor times preset");

    min_time_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(batch_active) && $past(ctrl[bpt_pkg::CB_SLOW_EXC]) |->
            $past(run_time) >= MIN_BATCH_CYC)
        else $error("batch ended before minimum time");

    grand_add_a: assert property (@(posedge pclk) disable iff (!presetn)
        done |=> grand_total == $past(grand_total) + $past(batch_cnt))
        else $error("grand total missed a completed batch");

    mode_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl[bpt_pkg::CB_PROT_OFF] |=> $stable(ctrl[bpt_pkg::CB_MODE_PRESET]))
        else $error("mode changed under program protection");

    cfg_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_req && !cfg_ok && !batch_active |=> !batch_active ##1 !batch_active)
        else $error("batch started without assigned functions");

    zero_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        zero_ret |=> disp_rate == 16'h0 && !outputs_on && !end_contact_output)
        else $error("outputs active during zero return");

    zero_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        zr_seq |-> $stable(batch_cnt))
        else $error("batch counter moved during zero return");
endmodule
`default_nettype wire

// ---- test/bpt_far_side.sv ----
/*
 * Far-side model: the shared contact (start or zero return) and the flow
 * pulse source. Assumes callers enter its tasks in step with pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module bpt_far_side (
    input wire logic pclk,
    output logic contact,
    output logic flow_pulse
);
    // open when idle
    // The contact is a normally open closure, so it rests low.
    initial begin
        contact = 1'b0;
        flow_pulse = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // bounded hold time
    // The hold is short because the bench shrinks the qualifying count.
    task automatic press(input int n);
        @(posedge pclk) contact <= 1'b1;
        repeat (n) @(posedge pclk);
        contact <= 1'b0;
    endtask
    // Pulses of one cycle with a gap, so each one is a separate event.
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge pclk) flow_pulse <= 1'b1;
            @(posedge pclk) flow_pulse <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- test/batch_preset_totalizer_tb_top.sv ----
/*
 * Self-checking bench for the batch preset totalizer over APB.
 * Assumes the far-side model drives the contact and the flow pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module batch_preset_totalizer_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic contact, flow_pulse, end_c, active, outs_on, zr_msg, irq;
    logic [15:0] flow_rate, disp_rate, cur;
    logic [3:0] err;
    int n_errors = 0;
    int n_checks = 0;

    // Counts are shrunk so every batch finishes within a few hundred cycles.
    bpt_top #(.START_MIN_CYC(10), .MIN_BATCH_CYC(33'd50), .ALT_CYC(8)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .start_contact_input(contact),
        .flow_pulse(flow_pulse), .flow_rate(flow_rate),
        .end_contact_output(end_c), .batch_active(active),
        .outputs_on(outs_on), .disp_rate(disp_rate), .current_value(cur),
        .disp_zr_msg(zr_msg), .disp_err_code(err), .irq(irq));
    bpt_far_side u_far (.pclk(pclk), .contact(contact),
        .flow_pulse(flow_pulse));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [7:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(what, rdata, e);
    endtask
    // Outputs are sampled on the falling edge, away from the drive edge.
    task automatic at(input int n);
        repeat (n) @(negedge pclk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // A hang counts as a mismatch and ends the run.
    initial begin
        repeat (3000) @(posedge pclk);
        n_errors++;
        results();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        flow_rate = 16'h0100;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd("factor", bpt_pkg::A_FACTOR, 32'h0000000A);
        rd("preset", bpt_pkg::A_PRESET, 32'h0000012C);
        rd("damp", bpt_pkg::A_DAMP, 32'h00000004);
        rd("unmapped", 8'h28, 32'h00000000);
        chk("slverr", rerr, 32'h1);
        $display("test reset values done");
        apb(1'b1, bpt_pkg::A_CTRL, 32'h02);
        rd("ctrl locked", bpt_pkg::A_CTRL, 32'h0);
        apb(1'b1, bpt_pkg::A_CTRL, 32'h01);
        apb(1'b1, bpt_pkg::A_CTRL, 32'h03);
        rd("ctrl mode", bpt_pkg::A_CTRL, 32'h03);
        apb(1'b1, bpt_pkg::A_CTRL, 32'h83);
        at(4);
        chk("refused", active, 32'h0);
        rd("refused flag", bpt_pkg::A_INT_STAT, 32'h08);
        apb(1'b1, bpt_pkg::A_INT_STAT, 32'h0F);
        $display("test protection done");
        apb(1'b1, bpt_pkg::A_FACTOR, 32'h2);
        apb(1'b1, bpt_pkg::A_PRESET, 32'h3);
        apb(1'b1, bpt_pkg::A_INT_MASK, 32'h2);
        apb(1'b1, bpt_pkg::A_CTRL, 32'h97);
        at(4);
        chk("active", active, 32'h1);
        chk("end closed", end_c, 32'h1);
        chk("start masked", irq, 32'h0);
        rd("target", bpt_pkg::A_TARGET, 32'h6);
        u_far.pulses(5);
        at(4);
        chk("short", active, 32'h1);
        u_far.pulses(1);
        at(4);
        chk("done", active, 32'h0);
        chk("end open", end_c, 32'h0);
        chk("irq", irq, 32'h1);
        rd("grand", bpt_pkg::A_GRAND, 32'h6);
        apb(1'b1, bpt_pkg::A_INT_STAT, 32'h0F);
        at(4);
        chk("irq clear", irq, 32'h0);
        $display("test keypad batch done");
        apb(1'b1, bpt_pkg::A_CTRL, 32'h17);
        u_far.press(14);
        at(4);
        chk("contact start", active, 32'h1);
        rd("cleared", bpt_pkg::A_BATCH, 32'h0);
        u_far.pulses(6);
        at(4);
        rd("grand 2", bpt_pkg::A_GRAND, 32'hC);
        $display("test contact batch done");
        apb(1'b1, bpt_pkg::A_CTRL, 32'h97);
        at(4);
        apb(1'b1, bpt_pkg::A_CTRL, 32'h1B);
        fork
            u_far.press(40);
            begin
                at(4);
                chk("outs off", outs_on, 32'h0);
                chk("end zr", end_c, 32'h0);
                chk("rate", disp_rate, 32'h0);
                chk("current", cur, 32'h0);
                chk("zr active", active, 32'h1);
                chk("err code", err, 32'h4);
                u_far.pulses(3);
                at(4);
                chk("zr msg", zr_msg, 32'h1);
                chk("err off", err, 32'h0);
            end
        join
        at(4);
        chk("outs on", outs_on, 32'h1);
        rd("frozen", bpt_pkg::A_BATCH, 32'h0);
        u_far.pulses(6);
        at(4);
        rd("grand 3", bpt_pkg::A_GRAND, 32'h12);
        $display("test zero return done");
        apb(1'b1, bpt_pkg::A_CTRL, 32'hD7);
        at(4);
        u_far.pulses(6);
        at(4);
        chk("min time", active, 32'h1);
        at(50);
        chk("slow done", active, 32'h0);
        rd("grand 4", bpt_pkg::A_GRAND, 32'h18);
        $display("test slow excitation done");
        // filter on with damping for a single rate step
        apb(1'b1, bpt_pkg::A_DAMP, 32'h2);
        apb(1'b1, bpt_pkg::A_CTRL, 32'h37);
        at(4);
        chk("rate flat", disp_rate, 32'h0100);
        @(posedge pclk) flow_rate <= 16'h0200;
        at(4);
        chk("rate smooth", disp_rate, 32'h0140);
        chk("current smooth", cur, 32'h0140);
        at(100);
        chk("rate settled", disp_rate, 32'h01FF);
        apb(1'b1, bpt_pkg::A_CTRL, 32'h17);
        at(4);
        chk("filter off", cur, 32'h0200);
        $display("test filter done");
        results();
    end
endmodule
`default_nettype wire
